//--- logic/adc_ctrl_defines.svh
// Register offsets, field positions, mode codes and the channel-off code of the converter control block
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
`define OFS_SC1      6'h00
`define OFS_SC2      6'h04
`define OFS_RH       6'h08
`define OFS_RL       6'h0C
`define OFS_CVH      6'h10
`define OFS_CVL      6'h14
`define OFS_CFG      6'h18
`define OFS_IST      6'h1C
`define OFS_IMSK     6'h20
`define SC1_CONVERSION_COMPLETE_FLAG     7
`define SC2_ACT      7
`define SC2_TRG      6
`define SC2_CFE      5
`define SC2_CGT      4
`define CFG_MODE_LSB 2
`define CFG_VALID    8
`define MODE_8       2'h0
`define MODE_10      2'h2
`define CHAN_OFF     5'h1F
`define IRQ_DONE     0
`define IRQ_LOST     1
`endif

//--- logic/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_s;
  typedef struct packed {
    logic       start;
    logic       abort;
    logic [4:0] channel;
    logic [1:0] mode;
  } conv_req_s;
  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } conv_res_s;
  typedef struct packed {
    conv_req_s   req;
    logic        conversion_complete_flag;
    logic        active;
    logic        trig_sel;
    logic        cmp_en;
    logic        cmp_gt;
    logic [1:0]  res_hi;
    logic [7:0]  res_lo;
    logic [1:0]  cv_hi;
    logic [7:0]  cv_lo;
    logic        lock;
    logic        valid;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        trig_prev;
    logic        waitreq;
    logic [31:0] rdata;
    logic        irq;
  } ctl_state_s;
endpackage

//--- logic/adc_result_compare_control.sv
// Converter control: trigger, result interlock, compare and register slave
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"

// Contract
// - Active flag is set on conversion start, cleared on finish or abort.
// - Trigger select 0 starts on control-one write, 1 on hardware trigger.
// - Compare enable bit turns automatic compare on or off.
// - Direction 0 means result below compare value, 1 means at or above.
// - High result holds top two bits; reads zero in 8-bit mode.
// - Results load on every completion unless compare enabled and false.
// - In 10-bit mode reading high result locks results until low read or a resolution change.
// - Completions during the lock are discarded, locked result stays.
// - In 8-bit mode reading high result never locks.
// - Changing resolution makes both results invalid until next completion.
// - Low result holds low eight bits or the whole 8-bit result.
// - High compare bits used only in 10-bit mode with compare enabled.
// - Low compare byte compared with low result byte in both modes.
// - Complete flag sets per compare rule; any control-one write or low read clears.
// - Control-one write aborts; restarts under trigger select 0 unless channel is all ones.
// - Resolution code 00 means 8-bit, 10 means 10-bit, others reserved.
module adc_result_compare_control (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire adc_ctrl_pkg::av_req_s   av_req,
  output logic [31:0]                  av_readdata,
  output logic                         av_waitrequest,
  input  wire logic                    hardware_trigger_input,
  input  wire adc_ctrl_pkg::conv_res_s conv_res,
  output adc_ctrl_pkg::conv_req_s      conv_req,
  output logic                         irq
);
  import adc_ctrl_pkg::*;

  logic [1:0] rst_sync;
  logic       rst_n;
  ctl_state_s s_reg;
  ctl_state_s s_next;

  // Unsigned magnitude test over the active width
  function automatic logic cmp_hit(input logic [1:0] mode, input logic [9:0] res,
                                   input logic [1:0] cvh, input logic [7:0] cvl,
                                   input logic gt);
    logic [9:0] r;
    logic [9:0] c;
    r = (mode == `MODE_10) ? res : {2'h0, res[7:0]};
    c = (mode == `MODE_10) ? {cvh, cvl} : {2'h0, cvl};
    cmp_hit = gt ? (r >= c) : (r < c);
  endfunction

  function automatic logic is_ten(input logic [1:0] mode);
    is_ten = (mode == `MODE_10);
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic       acc;
  logic       wr;
  logic       rd;
  logic       sc1_wr;
  logic       hw_edge;
  logic       go;
  logic       done_ok;
  logic       hit;
  logic       rh_rd10;
  logic       rl_rd;
  logic [1:0] ev;
  logic [1:0] new_mode;

  always_comb begin
    s_next = s_reg;
    s_next.req.start = 1'b0;
    s_next.req.abort = 1'b0;
    acc = (av_req.read || av_req.write) && !s_reg.waitreq;
    wr = acc && av_req.write && av_req.byteenable[0];
    rd = acc && av_req.read;
    sc1_wr = wr && av_req.address == `OFS_SC1;
    hw_edge = hardware_trigger_input && !s_reg.trig_prev;
    s_next.trig_prev = hardware_trigger_input;
    ev = 2'h0;
    new_mode = s_reg.req.mode;

    // Answer one cycle after the request; commit at the low-waitrequest edge
    if ((av_req.read || av_req.write) && s_reg.waitreq) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = 32'h0;
      unique case (av_req.address)
        `OFS_SC1:  s_next.rdata = {24'h0, s_reg.conversion_complete_flag, 2'h0, s_reg.req.channel};
        `OFS_SC2:  s_next.rdata = {24'h0, s_reg.active, s_reg.trig_sel,
                                   s_reg.cmp_en, s_reg.cmp_gt, 4'h0};
        // Stale high bits stay hidden outside 10-bit mode
        `OFS_RH:   s_next.rdata = {30'h0, (is_ten(s_reg.req.mode) ? s_reg.res_hi : 2'h0)};
        `OFS_RL:   s_next.rdata = {24'h0, s_reg.res_lo};
        `OFS_CVH:  s_next.rdata = {30'h0, s_reg.cv_hi};
        `OFS_CVL:  s_next.rdata = {24'h0, s_reg.cv_lo};
        `OFS_CFG:  s_next.rdata = {23'h0, s_reg.valid, 4'h0, s_reg.req.mode, 2'h0};
        `OFS_IST:  s_next.rdata = {30'h0, s_reg.irq_stat};
        `OFS_IMSK: s_next.rdata = {30'h0, s_reg.irq_mask};
        default:   s_next.rdata = 32'h0;
      endcase
    end else begin
      s_next.waitreq = 1'b1;
    end

    rh_rd10 = rd && av_req.address == `OFS_RH && is_ten(s_reg.req.mode);
    rl_rd = rd && av_req.address == `OFS_RL;

    // Clears first so that hardware sets below win
    if (rl_rd) begin
      s_next.lock = 1'b0;
      s_next.conversion_complete_flag = 1'b0;
    end
    if (rh_rd10) begin
      s_next.lock = 1'b1;
    end
    if (rd && av_req.address == `OFS_IST) begin
      s_next.irq_stat = 2'h0;
    end

    if (wr) begin
      unique case (av_req.address)
        `OFS_SC1: begin
          s_next.req.channel = av_req.writedata[4:0];
          s_next.conversion_complete_flag = 1'b0;
        end
        `OFS_SC2: begin
          // Reserved low bits are not stored
          s_next.trig_sel = av_req.writedata[`SC2_TRG];
          s_next.cmp_en = av_req.writedata[`SC2_CFE];
          s_next.cmp_gt = av_req.writedata[`SC2_CGT];
        end
        `OFS_CVH:  s_next.cv_hi = av_req.writedata[1:0];
        `OFS_CVL:  s_next.cv_lo = av_req.writedata[7:0];
        `OFS_CFG: begin
          new_mode = av_req.writedata[`CFG_MODE_LSB+:2];
          s_next.req.mode = new_mode;
          if (new_mode != s_reg.req.mode) begin
            s_next.valid = 1'b0;
            s_next.lock = 1'b0;
          end
        end
        `OFS_IMSK: s_next.irq_mask = av_req.writedata[1:0];
        default: begin
        end
      endcase
    end

    // Start sources; a channel of all ones only stops the converter
    go = ((sc1_wr && !s_reg.trig_sel) || (hw_edge && s_reg.trig_sel))
         && s_next.req.channel != `CHAN_OFF;
    done_ok = conv_res.done && s_reg.active && !sc1_wr && !go;
    hit = !s_reg.cmp_en
          || cmp_hit(s_reg.req.mode, conv_res.data, s_reg.cv_hi,
                     s_reg.cv_lo, s_reg.cmp_gt);

    if (s_reg.active && (sc1_wr || go)) begin
      s_next.req.abort = 1'b1;
      s_next.active = 1'b0;
    end
    if (go) begin
      s_next.req.start = 1'b1;
      s_next.active = 1'b1;
    end
    if (done_ok) begin
      s_next.active = 1'b0;
      if (hit) begin
        s_next.conversion_complete_flag = 1'b1;
        ev[`IRQ_DONE] = 1'b1;
        // A high-byte read in this same cycle already holds the pair
        if (s_reg.lock || rh_rd10) begin
          ev[`IRQ_LOST] = 1'b1;
        end else begin
          s_next.res_hi = is_ten(s_reg.req.mode) ? conv_res.data[9:8] : 2'h0;
          s_next.res_lo = conv_res.data[7:0];
          s_next.valid = 1'b1;
        end
      end
    end

    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.req.channel <= `CHAN_OFF;
      s_reg.waitreq <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign av_readdata = s_reg.rdata;
  assign av_waitrequest = s_reg.waitreq;
  assign conv_req = s_reg.req;
  assign irq = s_reg.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Helper views for the checks below
  logic       commit_sc1;
  logic       commit_rh;
  logic       commit_rl;
  logic       eight;
  logic       commit_wr;
  logic       ten;
  logic       hw_rise;
  assign commit_sc1 = av_req.write && !s_reg.waitreq && av_req.byteenable[0]
                      && av_req.address == `OFS_SC1;
  assign commit_rh = av_req.read && !s_reg.waitreq && av_req.address == `OFS_RH;
  assign commit_rl = av_req.read && !s_reg.waitreq && av_req.address == `OFS_RL;
  assign eight = s_reg.req.mode == `MODE_8;
  // Shared terms for the write, trigger and 10-bit mode checks
  assign commit_wr = av_req.write && !s_reg.waitreq && av_req.byteenable[0];
  assign ten = s_reg.req.mode == `MODE_10;
  assign hw_rise = hardware_trigger_input && !s_reg.trig_prev;

  sequence sw_start_s;
    commit_sc1 && !s_reg.trig_sel && av_req.writedata[4:0] != `CHAN_OFF;
  endsequence

  sequence hw_start_s;
    hardware_trigger_input && !s_reg.trig_prev && s_reg.trig_sel
    && s_reg.req.channel != `CHAN_OFF && !commit_sc1;
  endsequence

  sequence clean_done_s;
    conv_res.done && s_reg.active && !commit_sc1 && !conv_req.start
    && !(hardware_trigger_input && !s_reg.trig_prev && s_reg.trig_sel);
  endsequence

  active_start_a: assert property (sw_start_s |=> conv_req.start && s_reg.active)
    else $error("software start did not raise active");

  active_finish_a: assert property (clean_done_s |=> !s_reg.active)
    else $error("active not cleared at completion");

  hw_trigger_a: assert property (hw_start_s |=> conv_req.start ##1 !conv_req.start)
    else $error("hardware trigger start missing or not a pulse");

  sw_ignored_a: assert property (commit_sc1 && s_reg.trig_sel
                                 && !hw_rise |=> !conv_req.start)
    else $error("write started conversion under hardware trigger");

  chan_off_a: assert property (commit_sc1 && av_req.writedata[4:0] == `CHAN_OFF
                               |=> !conv_req.start && !s_reg.active)
    else $error("all-ones channel started a conversion");

  abort_a: assert property (commit_sc1 && s_reg.active |=> conv_req.abort)
    else $error("write during conversion did not abort");

  reserved_zero_a: assert property (av_req.read && s_reg.waitreq
                                    && av_req.address == `OFS_SC2
                                    |=> av_readdata[1:0] == 2'h0)
    else $error("reserved control bits read nonzero");

  high_zero_a: assert property (eight |-> s_reg.res_hi == 2'h0 || !s_reg.valid
                                || $past(!eight))
    else $error("high result nonzero in 8-bit mode");

  cmp_block_a: assert property (clean_done_s and (s_reg.cmp_en && !cmp_hit(
                                s_reg.req.mode, conv_res.data, s_reg.cv_hi,
                                s_reg.cv_lo, s_reg.cmp_gt))
                                |=> $stable(s_reg.res_lo) && $stable(s_reg.res_hi)
                                && !$rose(s_reg.conversion_complete_flag))
    else $error("failed compare updated results");

  load_a: assert property (clean_done_s and (!s_reg.cmp_en && !s_reg.lock
                           && !commit_rh)
                           |=> s_reg.res_lo == $past(conv_res.data[7:0])
                           && s_reg.conversion_complete_flag)
    else $error("result not loaded on plain completion");

  lock_set_a: assert property (commit_rh && ten
                               |=> s_reg.lock)
    else $error("high read did not lock in 10-bit mode");

  lock_hold_a: assert property (s_reg.lock && !commit_rl
                                |=> $stable(s_reg.res_lo) && $stable(s_reg.res_hi))
    else $error("locked result overwritten");

  no_lock8_a: assert property (commit_rh && eight && !s_reg.lock
                               |=> !s_reg.lock)
    else $error("high read locked in 8-bit mode");

  mode_inval_a: assert property (av_req.write && !s_reg.waitreq
                                 && av_req.byteenable[0] && av_req.address == `OFS_CFG
                                 && av_req.writedata[3:2] != s_reg.req.mode
                                 |=> !s_reg.valid ##1 1'b1)
    else $error("mode change kept results valid");

  conversion_complete_flag_clear_a: assert property (commit_rl && !conv_res.done |=> !s_reg.conversion_complete_flag
                                 && !s_reg.lock)
    else $error("low read did not clear flag and lock");

  irq_level_a: assert property (##1 irq == |(s_reg.irq_stat & s_reg.irq_mask))
    else $error("interrupt level disagrees with status and mask");

  answer_a: assert property ((av_req.read || av_req.write) && s_reg.waitreq
                             |=> !av_waitrequest ##1 av_waitrequest)
    else $error("bus answer not one cycle wide");

  // Register write paths
  trig_write_a: assert property (commit_wr && av_req.address == `OFS_SC2
                                 |=> s_reg.trig_sel == $past(av_req.writedata[`SC2_TRG]))
    else $error("trigger select not stored");

  cmp_en_write_a: assert property (commit_wr && av_req.address == `OFS_SC2
                                   |=> s_reg.cmp_en == $past(av_req.writedata[`SC2_CFE]))
    else $error("compare enable not stored");

  dir_write_a: assert property (commit_wr && av_req.address == `OFS_SC2
                                |=> s_reg.cmp_gt == $past(av_req.writedata[`SC2_CGT]))
    else $error("compare direction not stored");

  cvh_write_a: assert property (commit_wr && av_req.address == `OFS_CVH
                                |=> s_reg.cv_hi == $past(av_req.writedata[1:0]))
    else $error("high compare bits not stored");

  cvl_write_a: assert property (commit_wr && av_req.address == `OFS_CVL
                                |=> s_reg.cv_lo == $past(av_req.writedata[7:0]))
    else $error("low compare byte not stored");

  mode_follow_a: assert property (commit_wr && av_req.address == `OFS_CFG
                                  |=> conv_req.mode == $past(av_req.writedata[`CFG_MODE_LSB+:2]))
    else $error("resolution code not passed to converter");

  // Trigger and completion paths
  hw_off_a: assert property (hw_rise && !s_reg.trig_sel && !commit_sc1 |=> !conv_req.start)
    else $error("hardware trigger started under software select");

  idle_done_a: assert property (conv_res.done && !s_reg.active
                                |=> $stable(s_reg.res_lo) && !$rose(s_reg.conversion_complete_flag))
    else $error("completion accepted while idle");

  gt_pass_a: assert property (clean_done_s and (s_reg.cmp_en && s_reg.cmp_gt && eight
                              && conv_res.data[7:0] >= s_reg.cv_lo) |=> s_reg.conversion_complete_flag)
    else $error("at-or-above compare did not set complete flag");

  lt_pass_a: assert property (clean_done_s and (s_reg.cmp_en && !s_reg.cmp_gt && eight
                              && conv_res.data[7:0] < s_reg.cv_lo) |=> s_reg.conversion_complete_flag)
    else $error("below compare did not set complete flag");

  ten_cmp_a: assert property (clean_done_s and (s_reg.cmp_en && !s_reg.cmp_gt && ten
                              && conv_res.data >= {s_reg.cv_hi, s_reg.cv_lo}) |=> !$rose(s_reg.conversion_complete_flag))
    else $error("10-bit compare ignored high compare bits");

  hi_load_a: assert property (clean_done_s and (!s_reg.cmp_en && !s_reg.lock && !commit_rh && ten)
                              |=> s_reg.res_hi == $past(conv_res.data[9:8]))
    else $error("high result bits not loaded in 10-bit mode");

  lost_flag_a: assert property (clean_done_s and (!s_reg.cmp_en && s_reg.lock)
                                |=> s_reg.irq_stat[`IRQ_LOST])
    else $error("discarded result not flagged");

  // Stale high bits must not leak out after a switch to 8-bit
  rh_masked_a: assert property (av_req.read && s_reg.waitreq && av_req.address == `OFS_RH && !ten
                                |=> av_readdata == 32'h0)
    else $error("high result read nonzero outside 10-bit mode");

endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the converter result, compare and trigger control
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
module testbench;
  import adc_ctrl_pkg::*;
  logic        mclk                   = 1'b0;
  logic        resetn                 = 1'b0;
  av_req_s     av_req                 = '0;
  logic [31:0] av_readdata;
  logic        av_waitrequest;
  logic        hardware_trigger_input = 1'b0;
  conv_res_s   conv_res               = '0;
  conv_req_s   conv_req;
  logic        irq;
  int          bad_count              = 0;
  int          tests_run              = 0;
  int          starts                 = 0;
  int          aborts                 = 0;
  int          s0;
  logic [31:0] q;

  always #2.5 mclk = ~mclk;

  adc_result_compare_control adc_result_compare_control_inst (
    .mclk(mclk), .resetn(resetn), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .hardware_trigger_input(hardware_trigger_input),
    .conv_res(conv_res), .conv_req(conv_req), .irq(irq));

  // Pulses are counted so timing slack in the start path does not matter
  always @(posedge mclk) begin
    if (conv_req.start === 1'b1) starts++;
    if (conv_req.abort === 1'b1) aborts++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Request held until waitrequest is sampled low, released at that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge mclk);
    av_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge mclk);
    end while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av_req <= '0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic sw_start(input logic [4:0] ch);
    wr(`OFS_SC1, {27'h0, ch});
  endtask

  // Extra edge first so the start has landed before done arrives
  task automatic conv_done(input logic [9:0] data);
    repeat (2) @(posedge mclk);
    conv_res <= '{done: 1'b1, data: data};
    @(posedge mclk);
    conv_res <= '0;
  endtask

  task automatic t_regs;
    rdc(`OFS_SC2, 32'h0);
    wr(`OFS_SC2, 32'h70);
    rdc(`OFS_SC2, 32'h70);
    wr(`OFS_SC2, 32'h0);
    rdc(`OFS_SC2, 32'h0);
    rdc(6'h3C, 32'h0);
    wr(`OFS_CVH, 32'h2);
    rdc(`OFS_CVH, 32'h2);
    wr(`OFS_CVL, 32'h80);
    rdc(`OFS_CVL, 32'h80);
  endtask

  task automatic t_start;
    wr(`OFS_IMSK, 32'h0);
    bus(1'b0, `OFS_IST, 32'h0, q);
    s0 = starts;
    sw_start(5'h03);
    rdc(`OFS_SC2, 32'h80);
    sw_start(5'h04);
    repeat (2) @(posedge mclk);
    chk(aborts, 1);
    chk(starts, s0 + 2);
    conv_done(10'h05A);
    rdc(`OFS_SC2, 32'h0);
    rdc(`OFS_SC1, 32'h84);
    chk({31'h0, irq}, 32'h0);
    wr(`OFS_IMSK, 32'h3);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rdc(`OFS_IST, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rdc(`OFS_RL, 32'h5A);
    rdc(`OFS_SC1, 32'h04);
    s0 = starts;
    sw_start(5'h1F);
    repeat (3) @(posedge mclk);
    chk(starts, s0);
  endtask

  task automatic t_hw;
    wr(`OFS_SC2, 32'h40);
    s0 = starts;
    sw_start(5'h03);
    repeat (2) @(posedge mclk);
    chk(starts, s0);
    @(posedge mclk);
    hardware_trigger_input <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(starts, s0 + 1);
    rdc(`OFS_SC2, 32'hC0);
    chk({27'h0, conv_req.channel}, 32'h3);
    conv_done(10'h011);
    hardware_trigger_input <= 1'b0;
    rdc(`OFS_RL, 32'h11);
    wr(`OFS_SC2, 32'h0);
  endtask

  task automatic t_lock;
    wr(`OFS_CFG, 32'h8);
    rdc(`OFS_CFG, 32'h8);
    chk({30'h0, conv_req.mode}, 32'h2);
    sw_start(5'h03);
    conv_done(10'h2A5);
    rdc(`OFS_CFG, 32'h108);
    rdc(`OFS_RH, 32'h2);
    sw_start(5'h03);
    conv_done(10'h11B);
    rdc(`OFS_IST, 32'h3);
    rdc(`OFS_RL, 32'hA5);
    sw_start(5'h03);
    conv_done(10'h11B);
    rdc(`OFS_RH, 32'h1);
    rdc(`OFS_RL, 32'h1B);
    wr(`OFS_CFG, 32'h0);
    rdc(`OFS_RH, 32'h0);
    sw_start(5'h03);
    conv_done(10'h0C7);
    rdc(`OFS_RH, 32'h0);
    sw_start(5'h03);
    conv_done(10'h055);
    rdc(`OFS_RL, 32'h55);
  endtask

  // One conversion under a given mode and compare setup
  task automatic cmp_case(input logic [3:0] cfg, input logic [7:0] sc2, input logic [9:0] data,
                          input logic hit, input logic [7:0] lo_exp);
    wr(`OFS_CFG, {28'h0, cfg});
    wr(`OFS_SC2, {24'h0, sc2});
    sw_start(5'h03);
    conv_done(data);
    rdc(`OFS_SC1, {24'h0, hit, 7'h03});
    rdc(`OFS_RL, {24'h0, lo_exp});
  endtask

  task automatic t_cmp;
    cmp_case(4'h0, 8'h20, 10'h07F, 1'b1, 8'h7F);
    cmp_case(4'h0, 8'h20, 10'h080, 1'b0, 8'h7F);
    cmp_case(4'h0, 8'h30, 10'h080, 1'b1, 8'h80);
    cmp_case(4'h0, 8'h30, 10'h07F, 1'b0, 8'h80);
    cmp_case(4'h0, 8'h00, 10'h090, 1'b1, 8'h90);
    cmp_case(4'h8, 8'h30, 10'h280, 1'b1, 8'h80);
    cmp_case(4'h8, 8'h30, 10'h27F, 1'b0, 8'h80);
    cmp_case(4'h8, 8'h20, 10'h17F, 1'b1, 8'h7F);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_start();
    t_hw();
    t_lock();
    t_cmp();
    conclude();
  end

  // Whole run needs a few hundred cycles; this is far beyond it
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
